//--- pkg/tpc_pkg.sv
// constants, register map and encodings of the timer counter core
package tpc_pkg;
   localparam int CLK_HZ = 200_000_000;
   localparam int CNT_W = 16;
   localparam int PS_W = 3;
   localparam int DIV_W = 7;
   localparam int ADR_W = 4;
   localparam int CHAN_N = 1;
   // register byte addresses
   localparam logic [ADR_W-1:0] OFF_SC = 4'h0;
   localparam logic [ADR_W-1:0] OFF_CNT = 4'h4;
   localparam logic [ADR_W-1:0] OFF_MOD = 4'h8;
   localparam logic [ADR_W-1:0] OFF_PIN = 4'hc;
   // status/control field positions
   localparam int SC_FLAG = 7;
   localparam int SC_IRQ_EN = 6;
   localparam int SC_CENTER = 5;
   localparam int SC_CS_HI = 4;
   localparam int SC_CS_LO = 3;
   localparam int SC_PS_HI = 2;
   localparam int SC_PS_LO = 0;
   // pin/channel config field positions
   localparam int PIN_ELS_LO = 0;
   localparam int PIN_ELS_HI = 1;
   localparam int PIN_MODE_LO = 2;
   localparam int PIN_MODE_HI = 3;
   localparam int PIN_PULLUP = 4;
   // reset values
   localparam logic [6:0] SC_CTRL_RST = 7'h00;
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [CNT_W-1:0] MOD_RST = 16'h0000;
   localparam logic [4:0] PIN_RST = 5'h00;
   localparam logic [CNT_W-1:0] CNT_ALL_ONES = 16'hffff;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [1:0] ELS_NONE = 2'h0;
   // clock select encodings
   localparam logic [1:0] CS_OFF = 2'h0;
   localparam logic [1:0] CS_BUS = 2'h1;
   localparam logic [1:0] CS_FIXED = 2'h2;
   localparam logic [1:0] CS_EXT = 2'h3;
   localparam int SRC_FIXED = 0;
   localparam int SRC_EXT = 1;
   localparam int SRC_N = 2;
endpackage : tpc_pkg

//--- pkg/tpc_tick_if.sv
// tick signals between clock select, prescaler and counter core
`timescale 1ns/1ps
interface tpc_tick_if;
   logic [1:0] clk_sel;
   logic [2:0] ps_sel;
   logic src_tick;
   logic pre_tick;
   modport src (input clk_sel, output src_tick);
   modport pre (input clk_sel, input ps_sel, input src_tick, output pre_tick);
   modport core (output clk_sel, output ps_sel, input pre_tick);
endinterface : tpc_tick_if

//--- rtl/tpc_clk_src.sv
// clock source synchronizers and source selection
`timescale 1ns/1ps
module tpc_clk_src
   import tpc_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic fixed_system_clock,
   input wire logic external_timer_clock_in,
   tpc_tick_if.src tk
);
   logic [SRC_N-1:0] raw;
   logic [SRC_N-1:0] meta_reg;
   logic [SRC_N-1:0] sync_reg;
   logic [SRC_N-1:0] prev_reg;
   logic [SRC_N-1:0] rise;
   logic tick_reg;
   assign raw[SRC_FIXED] = fixed_system_clock;
   assign raw[SRC_EXT] = external_timer_clock_in;
   // source must stay below a quarter of mclk or edges are lost
   genvar i;
   generate
      for (i = 0; i < SRC_N; i++) begin : g_sync
         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               meta_reg[i] <= 1'b0;
               sync_reg[i] <= 1'b0;
               prev_reg[i] <= 1'b0;
            end else begin
               meta_reg[i] <= raw[i];
               sync_reg[i] <= meta_reg[i];
               prev_reg[i] <= sync_reg[i];
            end
         end
         assign rise[i] = sync_reg[i] & ~prev_reg[i];
      end
   endgenerate
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tick_reg <= 1'b0;
      end else begin
         unique case (tk.clk_sel)
            CS_OFF: tick_reg <= 1'b0;
            CS_BUS: tick_reg <= 1'b1;
            CS_FIXED: tick_reg <= rise[SRC_FIXED];
            CS_EXT: tick_reg <= rise[SRC_EXT];
         endcase
      end
   end
   assign tk.src_tick = tick_reg;
endmodule : tpc_clk_src

//--- rtl/tpc_prescaler.sv
// power-of-two prescaler behind the selected source
`timescale 1ns/1ps
module tpc_prescaler
   import tpc_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   tpc_tick_if.pre tk
);
   logic [DIV_W-1:0] div_reg;
   logic [DIV_W-1:0] mask;
   function automatic logic [DIV_W-1:0] ps_mask(input logic [PS_W-1:0] ps);
      logic [DIV_W:0] one_hot;
      one_hot = '0;
      one_hot[ps] = 1'b1;
      return DIV_W'(one_hot - 1'b1);
   endfunction : ps_mask
   assign mask = ps_mask(tk.ps_sel);
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         div_reg <= '0;
      end else if (tk.clk_sel == CS_OFF) begin
         div_reg <= '0;
      end else if (tk.src_tick) begin
         div_reg <= div_reg + 1'b1;
      end
   end
   assign tk.pre_tick = tk.src_tick & ((div_reg & mask) == mask);
endmodule : tpc_prescaler

//--- rtl/tpc_core.sv
// timer counter core with wishbone register slave
//
// Chosen here: the Wishbone register port and the address map.
`timescale 1ns/1ps
// Function
// - prescaler divides the chosen clock by a power of two, 1 to 128.
// - sixteen-bit counter, up free-running or modulo, or up/down when centered.
// - modulo of zero or all ones gives a free-running sixteen-bit count.
// - reading the count never disturbs counting.
// - any write to either count byte clears the counter.
// - after reset timer is off and pins are inputs without pullups.
// - clock select one-one feeds synchronized external clock to prescaler.
// - pin owned by timer ignores port settings, otherwise reverts to GPIO.
// - up mode sets overflow flag when count wraps to zero after modulo.
// - center mode sets overflow flag stepping down from the modulo value.
// - flag clears by read while set then zero write; one ignored.
// - new overflow during clear sequence restarts it, keeping the flag set.
// - overflow interrupt while flag and enable bit six are both set.
// - center select bit five picks up/down counting and centered channels.
// - clock select bits four and three disable or choose one of three sources.
// - prescale bits two to zero pick divisor after source selection.
// - one interrupt per channel plus one terminal-count interrupt.
// - select codes are off, bus clock, fixed clock, external pin.
// - prescale value n divides by two to the n.
// - reading one count byte latches both until the other is read or a count or status/control write.
// - writing one modulo byte blocks overflow until the other is written.
module tpc_core
   import tpc_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic fixed_system_clock,
   input wire logic external_timer_clock_in,
   input wire logic [CHAN_N-1:0] chan_irq_in,
   output logic [CHAN_N-1:0] chan_irq,
   output logic overflow_irq,
   output logic [CNT_W-1:0] count_value,
   output logic count_down,
   output logic center_aligned_pwm,
   output logic [1:0] channel_edge_level_select,
   output logic [1:0] channel_mode_select,
   output logic pin_timer_owned,
   output logic pin_pullup_en
);
   tpc_tick_if tk ();

   logic overflow_flag_reg;
   logic [6:0] sc_ctrl_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic down_reg;
   logic [CNT_W-1:0] mod_reg;
   logic mod_wait_hi_reg;
   logic mod_wait_lo_reg;
   logic clr_armed_reg;
   logic latched_reg;
   logic first_hi_reg;
   logic [CNT_W-1:0] cnt_buf_reg;
   logic [4:0] pin_reg;
   logic ack_reg;
   logic [31:0] dat_reg;
   logic irq_reg;
   logic [CHAN_N-1:0] chan_irq_reg;
   logic own_reg;
   logic pullup_reg;

   logic req;
   logic wr;
   logic rd;
   logic hit_sc;
   logic hit_cnt;
   logic hit_mod;
   logic hit_pin;
   logic [CNT_W-1:0] mod_eff;
   logic [CNT_W-1:0] cnt_next;
   logic down_next;
   logic ovf_raw;
   logic ovf_evt;
   logic clk_on;
   logic center;
   logic [CNT_W-1:0] cnt_rd;

   function automatic logic reg_hit(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] off);
      return adr[ADR_W-1:2] == off[ADR_W-1:2];
   endfunction : reg_hit

   // bus request taken once, in the cycle before ack
   assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wr = req & wb_we_i;
   assign rd = req & ~wb_we_i;
   assign hit_sc = reg_hit(wb_adr_i, OFF_SC);
   assign hit_cnt = reg_hit(wb_adr_i, OFF_CNT);
   assign hit_mod = reg_hit(wb_adr_i, OFF_MOD);
   assign hit_pin = reg_hit(wb_adr_i, OFF_PIN);

   assign clk_on = sc_ctrl_reg[SC_CS_HI:SC_CS_LO] != CS_OFF;
   assign center = sc_ctrl_reg[SC_CENTER];
   assign tk.clk_sel = sc_ctrl_reg[SC_CS_HI:SC_CS_LO];
   assign tk.ps_sel = sc_ctrl_reg[SC_PS_HI:SC_PS_LO];

   tpc_clk_src u_src (
      .mclk(mclk),
      .resetn(resetn),
      .fixed_system_clock(fixed_system_clock),
      .external_timer_clock_in(external_timer_clock_in),
      .tk(tk)
   );

   tpc_prescaler u_pre (
      .mclk(mclk),
      .resetn(resetn),
      .tk(tk)
   );

   // zero or all-ones modulo both act as full range
   assign mod_eff = (mod_reg == MOD_RST || mod_reg == CNT_ALL_ONES) ? CNT_ALL_ONES : mod_reg;

   always_comb begin
      cnt_next = cnt_reg;
      down_next = down_reg;
      ovf_raw = 1'b0;
      if (tk.pre_tick && clk_on) begin
         if (!center) begin
            down_next = 1'b0;
            if (cnt_reg >= mod_eff) begin
               cnt_next = CNT_RST;
               ovf_raw = 1'b1;
            end else begin
               cnt_next = cnt_reg + CNT_ONE;
            end
         end else if (!down_reg) begin
            if (cnt_reg >= mod_eff) begin
               down_next = 1'b1;
               cnt_next = cnt_reg - CNT_ONE;
               ovf_raw = 1'b1;
            end else begin
               cnt_next = cnt_reg + CNT_ONE;
            end
         end else begin
            if (cnt_reg == CNT_RST) begin
               down_next = 1'b0;
               cnt_next = CNT_ONE;
            end else begin
               cnt_next = cnt_reg - CNT_ONE;
            end
         end
      end
   end

   // half-written modulo holds off overflow reporting
   assign ovf_evt = ovf_raw & ~mod_wait_hi_reg & ~mod_wait_lo_reg;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= CNT_RST;
         down_reg <= 1'b0;
      end else if (wr && hit_cnt && (wb_sel_i[1:0] != 2'h0)) begin
         cnt_reg <= CNT_RST;
         down_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         down_reg <= down_next;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sc_ctrl_reg <= SC_CTRL_RST;
      end else if (wr && hit_sc && wb_sel_i[0]) begin
         sc_ctrl_reg <= wb_dat_i[6:0];
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mod_reg <= MOD_RST;
      end else if (wr && hit_mod) begin
         if (wb_sel_i[0]) begin
            mod_reg[7:0] <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            mod_reg[15:8] <= wb_dat_i[15:8];
         end
      end
   end

   // track which modulo byte is still owed after a single-byte write
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mod_wait_hi_reg <= 1'b0;
         mod_wait_lo_reg <= 1'b0;
      end else if (wr && hit_mod) begin
         if (wb_sel_i[1:0] == 2'h1) begin
            mod_wait_hi_reg <= 1'b1;
            mod_wait_lo_reg <= 1'b0;
         end else if (wb_sel_i[1:0] == 2'h2) begin
            mod_wait_lo_reg <= ~mod_wait_hi_reg;
            mod_wait_hi_reg <= 1'b0;
         end else if (wb_sel_i[1:0] == 2'h3) begin
            mod_wait_hi_reg <= 1'b0;
            mod_wait_lo_reg <= 1'b0;
         end
         if (wb_sel_i[1:0] == 2'h1 && mod_wait_lo_reg) begin
            mod_wait_hi_reg <= 1'b0;
         end
      end
   end

   // set beats clear in the same cycle
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         overflow_flag_reg <= 1'b0;
      end else if (ovf_evt) begin
         overflow_flag_reg <= 1'b1;
      end else if (wr && hit_sc && wb_sel_i[0] && !wb_dat_i[SC_FLAG] && clr_armed_reg) begin
         overflow_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         clr_armed_reg <= 1'b0;
      end else if (ovf_evt) begin
         clr_armed_reg <= 1'b0;
      end else if (rd && hit_sc && wb_sel_i[0] && overflow_flag_reg) begin
         clr_armed_reg <= 1'b1;
      end else if (wr && hit_sc && wb_sel_i[0] && !wb_dat_i[SC_FLAG]) begin
         clr_armed_reg <= 1'b0;
      end
   end

   // count read value; a full 16-bit read is coherent by itself
   assign cnt_rd = latched_reg ? cnt_buf_reg : cnt_reg;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         latched_reg <= 1'b0;
         first_hi_reg <= 1'b0;
         cnt_buf_reg <= CNT_RST;
      end else if ((wr && hit_cnt && (wb_sel_i[1:0] != 2'h0)) || (wr && hit_sc && wb_sel_i[0])) begin
         latched_reg <= 1'b0;
      end else if (rd && hit_cnt) begin
         if (latched_reg) begin
            if (first_hi_reg ? wb_sel_i[0] : wb_sel_i[1]) begin
               latched_reg <= 1'b0;
            end
         end else if (wb_sel_i[1:0] == 2'h1 || wb_sel_i[1:0] == 2'h2) begin
            latched_reg <= 1'b1;
            first_hi_reg <= wb_sel_i[1];
            cnt_buf_reg <= cnt_reg;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pin_reg <= PIN_RST;
      end else if (wr && hit_pin && wb_sel_i[0]) begin
         pin_reg <= wb_dat_i[4:0];
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req;
      end
   end

   // address bits three and two select one of four registers; unused bits read as zero
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         dat_reg <= '0;
      end else if (rd) begin
         dat_reg <= '0;
         if (hit_sc) begin
            dat_reg[7:0] <= {overflow_flag_reg, sc_ctrl_reg};
         end else if (hit_cnt) begin
            dat_reg[15:0] <= cnt_rd;
         end else if (hit_mod) begin
            dat_reg[15:0] <= mod_reg;
         end else if (hit_pin) begin
            dat_reg[4:0] <= pin_reg;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         irq_reg <= 1'b0;
         chan_irq_reg <= '0;
      end else begin
         irq_reg <= overflow_flag_reg & sc_ctrl_reg[SC_IRQ_EN];
         chan_irq_reg <= chan_irq_in;
      end
   end

   // pin ownership; port data and direction apply only while not owned
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         own_reg <= 1'b0;
         pullup_reg <= 1'b0;
      end else begin
         own_reg <= clk_on && (center || pin_reg[PIN_ELS_HI:PIN_ELS_LO] != ELS_NONE);
         pullup_reg <= clk_on && pin_reg[PIN_PULLUP] && (pin_reg[PIN_ELS_HI:PIN_ELS_LO] != ELS_NONE);
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign overflow_irq = irq_reg;
   assign chan_irq = chan_irq_reg;
   assign count_value = cnt_reg;
   assign count_down = down_reg;
   assign center_aligned_pwm = sc_ctrl_reg[SC_CENTER];
   assign channel_edge_level_select = pin_reg[PIN_ELS_HI:PIN_ELS_LO];
   assign channel_mode_select = pin_reg[PIN_MODE_HI:PIN_MODE_LO];
   assign pin_timer_owned = own_reg;
   assign pin_pullup_en = pullup_reg;
endmodule : tpc_core

//--- verif/tpc_clk_model.sv
// model of the external timer clock pin and the fixed system clock
`timescale 1ns/1ps
module tpc_clk_model
(
   input wire logic mclk,
   input wire logic run,
   output logic fixed_system_clock,
   output logic external_timer_clock_in
);
   logic [3:0] div_reg = 4'h0;
   // both sources stand low while idle, like a stopped oscillator
   always @(posedge mclk) begin
      div_reg <= run ? div_reg + 4'h1 : 4'h0;
   end
   assign fixed_system_clock = div_reg[3];
   // eighth of the bus rate, below the quarter limit of the synchronizer
   assign external_timer_clock_in = div_reg[2];
endmodule : tpc_clk_model

//--- verif/tpc_core_properties.sv
// port assertions for the timer counter core
`timescale 1ns/1ps
module tpc_core_props
   import tpc_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic [CHAN_N-1:0] chan_irq_in,
   input wire logic [CHAN_N-1:0] chan_irq,
   input wire logic overflow_irq,
   input wire logic [CNT_W-1:0] count_value,
   input wire logic pin_timer_owned,
   input wire logic pin_pullup_en
);
   logic tk;
   logic sc_wr;
   logic cnt_wr;
   logic [6:0] sc_reg;
   logic [1:0] age_reg;
   assign tk = wb_cyc_i & wb_stb_i & !wb_ack_o;
   assign sc_wr = tk & wb_we_i & wb_sel_i[0] & (wb_adr_i[3:2] == OFF_SC[3:2]);
   assign cnt_wr = tk & wb_we_i & (|wb_sel_i[1:0]) & (wb_adr_i[3:2] == OFF_CNT[3:2]);
   // shadow of the control bits; tick pipeline needs a few cycles to settle
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sc_reg <= SC_CTRL_RST;
      end else if (sc_wr) begin
         sc_reg <= wb_dat_i[6:0];
      end
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         age_reg <= 2'h0;
      end else if (sc_wr) begin
         age_reg <= 2'h0;
      end else if (age_reg != 2'h3) begin
         age_reg <= age_reg + 2'h1;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   property p_ack;
      tk |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not one pulse");
   property p_clear;
      cnt_wr |=> count_value <= 16'h0001;
   endproperty
   a_clear: assert property (p_clear) else $error("count not cleared");
   property p_hold;
      age_reg == 2'h3 && sc_reg[4:3] == CS_OFF && !cnt_wr && !sc_wr |=> $stable(count_value);
   endproperty
   a_hold: assert property (p_hold) else $error("count moved while stopped");
   property p_step;
      age_reg == 2'h3 && sc_reg[5:0] == 6'h08 && !cnt_wr && !sc_wr
         |=> count_value == $past(count_value) + 16'h0001 || count_value == 16'h0000;
   endproperty
   a_step: assert property (p_step) else $error("bad step at divide one");
   property p_pins_off;
      age_reg == 2'h3 && sc_reg[4:3] == CS_OFF |-> !pin_timer_owned && !pin_pullup_en;
   endproperty
   a_pins_off: assert property (p_pins_off) else $error("pin held while off");
   property p_pullup;
      pin_pullup_en |-> pin_timer_owned;
   endproperty
   a_pullup: assert property (p_pullup) else $error("pullup without timer pin");
   property p_irq;
      overflow_irq |-> $past(sc_reg[6]);
   endproperty
   a_irq: assert property (p_irq) else $error("irq while disabled");
   property p_chan;
      chan_irq == $past(chan_irq_in);
   endproperty
   a_chan: assert property (p_chan) else $error("channel request lost");
   property p_wrap;
      age_reg == 2'h3 && sc_reg == 7'h48 && $past(count_value) != 16'h0000 && count_value == 16'h0000
         && !$past(cnt_wr) |-> ##[1:2] overflow_irq;
   endproperty
   a_wrap: assert property (p_wrap) else $error("no irq after wrap");
   c_flag: cover property (overflow_irq);
   c_clear: cover property (cnt_wr);
   c_pull: cover property (pin_pullup_en);
endmodule : tpc_core_props

bind tpc_core tpc_core_props i_props (.mclk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
   .wb_dat_i, .wb_ack_o, .chan_irq_in, .chan_irq, .overflow_irq, .count_value, .pin_timer_owned, .pin_pullup_en);

//--- verif/test_timer_pwm_counter_core.sv
// self-checking bench for the timer counter core
`timescale 1ns/1ps
module test_timer_pwm_counter_core
   import tpc_pkg::*;
;
   localparam logic RD = 1'b0;
   localparam logic WR = 1'b1;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic run = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [ADR_W-1:0] wb_adr_i = 4'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rdat;
   logic [CHAN_N-1:0] chan_irq_in = '0, chan_irq, cx;
   logic [CNT_W-1:0] count_value, v0, m, dd;
   logic wb_ack_o, overflow_irq, count_down, center_aligned_pwm, pin_timer_owned, pin_pullup_en, dn;
   logic fixed_system_clock, external_timer_clock_in;
   logic [1:0] channel_edge_level_select, channel_mode_select;
   int bad_count = 0, checks = 0, cyc_n = 0, t_tk, t0, e, per, ps;
   tpc_core i_dut (.mclk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
      .wb_ack_o, .fixed_system_clock, .external_timer_clock_in, .chan_irq_in, .chan_irq, .overflow_irq,
      .count_value, .count_down, .center_aligned_pwm, .channel_edge_level_select, .channel_mode_select,
      .pin_timer_owned, .pin_pullup_en);
   tpc_clk_model i_src (.mclk, .run, .fixed_system_clock, .external_timer_clock_in);
   always #2.5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 40000) begin
         bad_count++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // one classic cycle, held until ack is sampled
   task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
      t_tk = cyc_n;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      do @(posedge mclk); while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge mclk);
   endtask : bus
   function automatic int exp_ticks(input int dt, input int p, input int s);
      return dt / (p << s);
   endfunction : exp_ticks
   task automatic run_mod(input logic c);
      m = 16'($urandom_range(40, 8));
      dd = 16'h0000;
      dn = 1'b0;
      bus(WR, OFF_SC, 4'h1, 32'h0000_0000);
      bus(WR, OFF_MOD, 4'h3, {16'h0000, m});
      bus(RD, OFF_MOD, 4'h3, 32'h0000_0000);
      chk(rdat, {16'h0000, m}, "modulo readback");
      bus(WR, OFF_CNT, 4'h3, 32'h0000_0000);
      bus(WR, OFF_SC, 4'h1, {26'h000_0000, c, 5'h08} | 32'h0000_0040);
      repeat (4 * m + 8) begin
         @(posedge mclk);
         dd = (count_value > dd) ? count_value : dd;
         dn = dn | count_down;
      end
      chk(dd, m, "peak");
      chk(dn, c, "down seen");
      chk(center_aligned_pwm, c, "center out");
      chk(overflow_irq, 1'b1, "irq");
      bus(RD, OFF_SC, 4'h1, 32'h0000_0000);
      chk(rdat[7:0], {2'h3, c, 5'h08}, "flag");
      // a fresh overflow lands between the arming read and the clear
      repeat (2 * m + 4) @(posedge mclk);
      bus(WR, OFF_SC, 4'h1, {26'h000_0000, c, 5'h08} | 32'h0000_0040);
      bus(RD, OFF_SC, 4'h1, 32'h0000_0000);
      chk(rdat[SC_FLAG], 1'b1, "late clear");
      bus(WR, OFF_SC, 4'h1, 32'h0000_0080);
      bus(RD, OFF_SC, 4'h1, 32'h0000_0000);
      chk(rdat[SC_FLAG], 1'b1, "write one");
      bus(WR, OFF_SC, 4'h1, 32'h0000_0000);
      bus(RD, OFF_SC, 4'h1, 32'h0000_0000);
      chk(rdat[7:0], 8'h00, "cleared");
      chk(overflow_irq, 1'b0, "irq off");
      $display("test modulo %0d center %0d done", m, c);
   endtask : run_mod
   initial begin
      void'($urandom(82725));
      repeat (5) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      for (int i = 0; i < 4; i++) begin
         bus(RD, 4'(i * 4), 4'hf, 32'h0000_0000);
         chk(rdat, 32'h0000_0000, "reset value");
      end
      $display("test reset done");
      run <= 1'b1;
      bus(WR, OFF_PIN, 4'h1, 32'h0000_0000);
      for (int s = 1; s < 4; s++) begin
         for (int p = 0; p < (s == 1 ? 8 : 2); p++) begin
            ps = (s == 1) ? p : $urandom_range(2);
            per = (s == 1) ? 1 : (s == 2 ? 16 : 8);
            bus(WR, OFF_SC, 4'h1, 32'h0000_0000);
            bus(WR, OFF_SC, 4'h1, 32'(s * 8 + ps));
            bus(RD, OFF_CNT, 4'h3, 32'h0000_0000);
            v0 = rdat[15:0];
            t0 = t_tk;
            repeat ((12 * per) << ps) @(posedge mclk);
            bus(RD, OFF_CNT, 4'h3, 32'h0000_0000);
            e = exp_ticks(t_tk - t0, per, ps);
            dd = rdat[15:0] - v0;
            chk(dd >= e && dd <= e + 1, 1'b1, "ticks");
            bus(WR, OFF_CNT, 4'($urandom_range(2, 1)), $urandom);
            bus(RD, OFF_CNT, 4'h3, 32'h0000_0000);
            chk(rdat[15:0] <= 16'h0003, 1'b1, "after write");
         end
      end
      $display("test sources done");
      bus(WR, OFF_SC, 4'h1, 32'h0000_0000);
      bus(RD, OFF_CNT, 4'h3, 32'h0000_0000);
      v0 = rdat[15:0];
      repeat (40) @(posedge mclk);
      bus(RD, OFF_CNT, 4'h3, 32'h0000_0000);
      chk(rdat[15:0], v0, "held");
      bus(WR, OFF_SC, 4'h1, 32'h0000_0008);
      bus(RD, OFF_CNT, 4'h3, 32'h0000_0000);
      v0 = rdat[15:0];
      t0 = t_tk;
      bus(RD, OFF_CNT, 4'h1, 32'h0000_0000);
      dd[7:0] = rdat[7:0];
      e = t_tk - t0;
      repeat (600) @(posedge mclk);
      bus(RD, OFF_CNT, 4'h2, 32'h0000_0000);
      dd[15:8] = rdat[15:8];
      chk(16'(dd - v0 - 16'(e)) <= 16'h0001, 1'b1, "latched pair");
      for (int i = 0; i < 2; i++) begin
         bus(WR, OFF_MOD, 4'h3, i ? 32'h0000_0000 : 32'h0000_ffff);
         bus(WR, OFF_CNT, 4'h3, 32'h0000_0000);
         repeat (300) @(posedge mclk);
         bus(RD, OFF_CNT, 4'h3, 32'h0000_0000);
         chk(rdat[15:0] > 16'h00ff, 1'b1, "free run");
      end
      $display("test hold and latch done");
      run_mod(1'b0);
      run_mod(1'b1);
      bus(WR, OFF_MOD, 4'h3, 32'h0000_0000);
      bus(WR, OFF_MOD, 4'h1, 32'h0000_0005);
      bus(WR, OFF_CNT, 4'h3, 32'h0000_0000);
      bus(WR, OFF_SC, 4'h1, 32'h0000_0008);
      repeat (40) @(posedge mclk);
      bus(RD, OFF_SC, 4'h1, 32'h0000_0000);
      chk(rdat[SC_FLAG], 1'b0, "half modulo");
      bus(WR, OFF_MOD, 4'h2, 32'h0000_0000);
      repeat (20) @(posedge mclk);
      bus(RD, OFF_SC, 4'h1, 32'h0000_0000);
      chk(rdat[SC_FLAG], 1'b1, "full modulo");
      bus(WR, OFF_PIN, 4'h1, 32'h0000_0019);
      repeat (3) @(posedge mclk);
      chk({pin_timer_owned, pin_pullup_en, channel_edge_level_select}, 4'hd, "pins on");
      chk(channel_mode_select, 2'h2, "mode field");
      bus(RD, OFF_PIN, 4'h1, 32'h0000_0000);
      chk(rdat, 32'h0000_0019, "pin readback");
      bus(WR, OFF_SC, 4'h1, 32'h0000_0000);
      repeat (3) @(posedge mclk);
      chk({pin_timer_owned, pin_pullup_en, channel_edge_level_select}, 4'h1, "pins off");
      repeat (8) begin
         cx = CHAN_N'($urandom);
         chan_irq_in <= cx;
         repeat (2) @(posedge mclk);
         chk(chan_irq, cx, "channel request");
      end
      $display("test modulo, pins and requests done");
      report_and_stop();
   end
endmodule : test_timer_pwm_counter_core
